// ===== hw/tpcc_payload_cfg.sv
// Transmit and receive payload control: global config, indirect access, channel datapath.
// Assumes Avalon-MM master per its spec and a framer that delivers one beat per channel.
//
// How it works
// - Read flag set makes engine load data register
// - Busy flag shows access; new accesses refused meanwhile
// - Control bit 7 picks read or write
// - Tx snapshot locks first-frame signaling per multiframe
// - Rx snapshot holds first-frame signaling when in sync
// - Global or per-channel trunk code replaces signaling
// - Suppression code 000 passes data; 101-111 pass too
// - Code 001 sets bit 8 of zero channels, bit 7 in signaling frames
// - Code 010 forces bit 8 on every channel
// - Code 011 sets bit 7 of zero channels
// - Code 100 substitutes 10011000 for zero channels
// - Global code 000 defers to per-channel substitution
// - Global code 001 sends per-channel data trunk code
// - Codes 010 and 011 send A-law, mu-law milliwatt
// - Tx code 100 sends receive loopback data
// - Nibble-position bit in ESF keeps upper two signaling bits, clears lower two
// - Master enable gates all transmit payload functions
`timescale 1ns/1ps
module tpcc_payload_cfg (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Avalon-MM slave
	input  wire logic [tpcc_pkg::ADDR_W-1:0]   address,
	input  wire logic                          read,
	input  wire logic                          write,
	input  wire logic [31:0]                   writedata,
	input  wire logic [3:0]                    byteenable,
	output logic      [31:0]                   readdata,
	output logic                               waitrequest,
	// Framer status
	input  wire logic                          superFrameFmt,
	input  wire logic                          esfFormat,
	input  wire logic                          rxInSync,
	// Transmit stream
	input  wire tpcc_pkg::tpcc_beat_t          txIn,
	input  wire logic [7:0]                    txLoopData,
	output tpcc_pkg::tpcc_beat_t               txOut,
	// Receive stream
	input  wire tpcc_pkg::tpcc_beat_t          rxIn,
	output tpcc_pkg::tpcc_beat_t               rxOut
);
	import tpcc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic ind_ok(input logic [6:0] a);
		ind_ok = (a >= IND_SUB_LO && a <= IND_SUB_HI) ||
			(a >= IND_DTRK_LO && a <= IND_DTRK_HI) ||
			(a >= IND_TRK_LO && a <= IND_TRK_HI);
	endfunction : ind_ok

	function automatic logic [6:0] ind_slot(input logic [6:0] a);
		if (a >= IND_TRK_LO)
			ind_slot = 7'(a - IND_TRK_LO + 7'(2 * CHANNELS));
		else if (a >= IND_DTRK_LO)
			ind_slot = 7'(a - IND_DTRK_LO + 7'(CHANNELS));
		else
			ind_slot = 7'(a - IND_SUB_LO);
	endfunction : ind_slot

	function automatic logic [7:0] subst_data(input logic [2:0] sel, input logic [7:0] d,
		input logic [7:0] dtrk, input logic [7:0] lb, input logic [2:0] ph, input logic lbOk);
		case (sel)
			SUB_DTRK:  subst_data = dtrk;
			SUB_ALAW:  subst_data = ALAW_MW[ph];
			SUB_MULAW: subst_data = MULAW_MW[ph];
			SUB_LOOP:  subst_data = lbOk ? lb : d;
			default:   subst_data = d;
		endcase
	endfunction : subst_data

	// Bit 8 is the lsb, bit 7 the next one up
	function automatic logic [7:0] zero_suppress(input logic [2:0] sel, input logic [7:0] d,
		input logic sigFrame);
		case (sel)
			ZCS_GTE:  zero_suppress = (d == 8'h00) ? (sigFrame ? 8'h02 : 8'h01) : d;
			ZCS_JAM:  zero_suppress = d | 8'h01;
			ZCS_BELL: zero_suppress = (d == 8'h00) ? 8'h02 : d;
			ZCS_DDS:  zero_suppress = (d == 8'h00) ? DDS_BYTE : d;
			default:  zero_suppress = d;
		endcase
	endfunction : zero_suppress

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM handshake: one wait cycle, then a one-cycle answer

	logic             waitReg;
	logic [31:0]      readdataReg;
	logic [7:0]       wordIdx;
	logic             wrStb;
	logic [1:0][7:0]  unitRd;
	logic [1:0]       unitHit;
	tpcc_beat_t [1:0] unitOut;

	assign wordIdx     = address[ADDR_W-1:2];
	assign wrStb       = write && !waitReg && byteenable[0];
	assign waitrequest = waitReg;
	assign readdata    = readdataReg;
	assign txOut       = unitOut[0];
	assign rxOut       = unitOut[1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			waitReg <= 1'b1;
		else if (!waitReg)
			waitReg <= 1'b1;
		else if (read || write)
			waitReg <= 1'b0;
	end

	// Data latched one edge early so readdata stands at the answering edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			readdataReg <= 32'h00000000;
		else if (read && waitReg)
			readdataReg <= {24'h000000, unitHit[0] ? unitRd[0] : (unitHit[1] ? unitRd[1] : 8'h00)};
	end

	////////////////////////////////////////////////////////////////////////////
	// One unit each for transmit (0) and receive (1)

	for (genvar u = 0; u < 2; u++) begin : g_unit
		localparam logic [7:0] I_STAT = (u == 0) ? IDX_TX_STATUS : IDX_RX_STATUS;
		localparam logic [7:0] I_CTRL = (u == 0) ? IDX_TX_CTRL : IDX_RX_CTRL;
		localparam logic [7:0] I_DATA = (u == 0) ? IDX_TX_DATA : IDX_RX_DATA;
		localparam logic [7:0] I_CFG  = (u == 0) ? IDX_TX_CFG : IDX_RX_CFG;
		localparam logic [7:0] I_ENA  = (u == 0) ? IDX_TX_ENA : IDX_NONE;
		localparam logic [7:0] CFG_RST = (u == 0) ? TX_CFG_RST : RX_CFG_RST;
		// Receive side has no suppression field and no loopback code
		localparam logic [7:0] CFG_MASK = (u == 0) ? 8'hFF : 8'hC7;

		tpcc_acc_t     accState;
		logic [3:0]    accCnt;
		logic [7:0]    ctrlReg;
		logic [7:0]    dataReg;
		logic [7:0]    cfgReg;
		logic [7:0]    enaReg;
		logic [7:0]    mem [0:3*CHANNELS-1];
		logic [3:0]    snap [0:CHANNELS-1];
		logic [2:0]    mwPhase;
		tpcc_beat_t    outReg;
		logic          busy;
		tpcc_beat_t    inBeat;
		logic [7:0]    subRow;
		logic [7:0]    dtrkRow;
		logic [7:0]    trkRow;
		logic          snapOn;
		logic          masterOn;
		logic [3:0]    sigSel;
		logic [3:0]    sigTrk;
		logic [3:0]    sigOut;
		logic [2:0]    subSel;
		logic [7:0]    dataSub;
		logic [7:0]    dataOut;

		assign busy   = (accState != ACC_IDLE);
		assign inBeat = (u == 0) ? txIn : rxIn;

		// Register read mux
		always_comb begin
			unitHit[u] = 1'b1;
			case (wordIdx)
				I_STAT:  unitRd[u] = {7'h00, busy};
				I_CTRL:  unitRd[u] = ctrlReg;
				I_DATA:  unitRd[u] = dataReg;
				I_CFG:   unitRd[u] = cfgReg;
				default: begin
					// Receive unit has no enable register; its index stays unmapped
					unitRd[u]  = (u == 0 && wordIdx == I_ENA) ? enaReg : 8'h00;
					unitHit[u] = (u == 0 && wordIdx == I_ENA);
				end
			endcase
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				cfgReg <= CFG_RST;
				enaReg <= ENA_RST;
			end else if (wrStb && wordIdx == I_CFG) begin
				cfgReg <= writedata[7:0] & CFG_MASK;
			end else if (wrStb && u == 0 && wordIdx == I_ENA) begin
				enaReg <= writedata[7:0] & 8'h09;
			end
		end

		////////////////////////////////////////////////////////////////////////
		// Indirect access engine

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				accState <= ACC_IDLE;
				accCnt   <= 4'h0;
				ctrlReg  <= CTRL_RST;
				dataReg  <= DATA_RST;
				for (int i = 0; i < 3 * CHANNELS; i++)
					mem[i] <= 8'h00;
			end else begin
				case (accState)
					ACC_IDLE: begin
						// Writes to control or data while busy are dropped
						if (wrStb && wordIdx == I_CTRL) begin
							ctrlReg  <= writedata[7:0];
							accCnt   <= ACCESS_CYCLES - 4'h1;
							accState <= ACC_RUN;
						end else if (wrStb && wordIdx == I_DATA) begin
							dataReg <= writedata[7:0];
						end
					end
					ACC_RUN: begin
						if (accCnt != 4'h0) begin
							accCnt <= accCnt - 4'h1;
						end else begin
							accState <= ACC_IDLE;
							if (ctrlReg[CTRL_RWN_BIT]) begin
								dataReg <= ind_ok(ctrlReg[6:0]) ?
									mem[ind_slot(ctrlReg[6:0])] : 8'h00;
							end else if (ind_ok(ctrlReg[6:0])) begin
								mem[ind_slot(ctrlReg[6:0])] <= dataReg;
							end
						end
					end
					default: accState <= ACC_IDLE;
				endcase
			end
		end

		////////////////////////////////////////////////////////////////////////
		// Channel datapath

		always_comb begin
			subRow   = 8'h00;
			dtrkRow  = 8'h00;
			trkRow   = 8'h00;
			if (inBeat.chan < 5'(CHANNELS)) begin
				subRow  = mem[inBeat.chan];
				dtrkRow = mem[7'(inBeat.chan) + 7'(CHANNELS)];
				trkRow  = mem[7'(inBeat.chan) + 7'(2 * CHANNELS)];
			end
		end

		// Receive snapshot only applies while the framer is in sync
		assign snapOn   = cfgReg[CFG_SNAP_BIT] && superFrameFmt &&
			((u == 0) || rxInSync);
		assign masterOn = (u == 0) ? enaReg[ENA_MASTER_BIT] : 1'b1;

		always_comb begin
			sigSel = inBeat.sig;
			if (snapOn && !inBeat.mfStart && inBeat.chan < 5'(CHANNELS))
				sigSel = snap[inBeat.chan];
			sigTrk = (cfgReg[CFG_TRUNK_BIT] || trkRow[CH_TRUNK_BIT]) ?
				trkRow[3:0] : sigSel;
			sigOut = sigTrk;
			if (u == 0 && enaReg[ENA_SIG_NIBBLE_POSITION_BIT] && esfFormat)
				sigOut = {sigTrk[3:2], 2'b00};
			subSel = cfgReg[CFG_SUBST_LSB +: 3];
			if (subSel == SUB_NONE)
				subSel = subRow[CH_SUBST_LSB +: 3];
			dataSub = subst_data(subSel, inBeat.data, dtrkRow, txLoopData, mwPhase, u == 0);
			dataOut = (u == 0) ?
				zero_suppress(cfgReg[CFG_ZCS_LSB +: 3], dataSub, inBeat.sigFrame) : dataSub;
		end

		// Snapshot stores at multiframe start; milliwatt phase steps once per frame
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				for (int i = 0; i < CHANNELS; i++)
					snap[i] <= 4'h0;
			end else if (inBeat.valid && inBeat.mfStart && inBeat.chan < 5'(CHANNELS)) begin
				snap[inBeat.chan] <= inBeat.sig;
			end
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n)
				mwPhase <= 3'h0;
			else if (inBeat.valid && inBeat.chan == 5'(CHANNELS - 1))
				mwPhase <= mwPhase + 3'h1;
		end

		// One cycle of latency; disabled transmit passes the beat untouched
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				outReg <= '0;
			end else begin
				outReg <= inBeat;
				if (inBeat.valid && masterOn) begin
					outReg.data <= dataOut;
					outReg.sig  <= sigOut;
				end
			end
		end

		assign unitOut[u] = outReg;
	end
endmodule : tpcc_payload_cfg

// ===== shared/tpcc_pkg.sv
// Constants, field layout and carrier types of the payload control config block.
// Assumes one 50 MHz clock domain and a 32-bit Avalon-MM register bus.
package tpcc_pkg;
	localparam int          ADDR_W        = 10;
	localparam int          CHANNELS      = 24;
	// Register word indices; byte address is four times the index
	localparam logic [7:0]  IDX_TX_STATUS = 8'hC8;
	localparam logic [7:0]  IDX_TX_CTRL   = 8'hC9;
	localparam logic [7:0]  IDX_TX_DATA   = 8'hCA;
	localparam logic [7:0]  IDX_TX_CFG    = 8'hCB;
	localparam logic [7:0]  IDX_TX_ENA    = 8'hCC;
	localparam logic [7:0]  IDX_RX_STATUS = 8'hCD;
	localparam logic [7:0]  IDX_RX_CTRL   = 8'hCE;
	localparam logic [7:0]  IDX_RX_DATA   = 8'hCF;
	localparam logic [7:0]  IDX_RX_CFG    = 8'hD0;
	localparam logic [7:0]  IDX_NONE      = 8'hFF;
	// Field positions
	localparam int          CFG_SNAP_BIT  = 7;
	localparam int          CFG_TRUNK_BIT = 6;
	localparam int          CFG_ZCS_LSB   = 3;
	localparam int          CFG_SUBST_LSB = 0;
	localparam int          CTRL_RWN_BIT  = 7;
	localparam int          ENA_SIG_NIBBLE_POSITION_BIT  = 3;
	localparam int          ENA_MASTER_BIT = 0;
	localparam int          CH_TRUNK_BIT  = 4;
	localparam int          CH_SUBST_LSB  = 5;
	// Reset values
	localparam logic [7:0]  TX_CFG_RST    = 8'h80;
	localparam logic [7:0]  RX_CFG_RST    = 8'h80;
	localparam logic [7:0]  ENA_RST       = 8'h00;
	localparam logic [7:0]  CTRL_RST      = 8'h00;
	localparam logic [7:0]  DATA_RST      = 8'h00;
	// Indirect address ranges
	localparam logic [6:0]  IND_SUB_LO    = 7'h01;
	localparam logic [6:0]  IND_SUB_HI    = 7'h18;
	localparam logic [6:0]  IND_DTRK_LO   = 7'h21;
	localparam logic [6:0]  IND_DTRK_HI   = 7'h38;
	localparam logic [6:0]  IND_TRK_LO    = 7'h41;
	localparam logic [6:0]  IND_TRK_HI    = 7'h58;
	// Timing count of one indirect access, in clock cycles
	localparam logic [3:0]  ACCESS_CYCLES = 4'h4;
	// Zero code suppression and substitution codes
	localparam logic [2:0]  ZCS_NONE = 3'h0;
	localparam logic [2:0]  ZCS_GTE  = 3'h1;
	localparam logic [2:0]  ZCS_JAM  = 3'h2;
	localparam logic [2:0]  ZCS_BELL = 3'h3;
	localparam logic [2:0]  ZCS_DDS  = 3'h4;
	localparam logic [7:0]  DDS_BYTE = 8'h98;
	localparam logic [2:0]  SUB_NONE  = 3'h0;
	localparam logic [2:0]  SUB_DTRK  = 3'h1;
	localparam logic [2:0]  SUB_ALAW  = 3'h2;
	localparam logic [2:0]  SUB_MULAW = 3'h3;
	localparam logic [2:0]  SUB_LOOP  = 3'h4;
	localparam logic [0:7][7:0] ALAW_MW = {8'h34, 8'h21, 8'h21, 8'h34, 8'hB4, 8'hA1, 8'hA1, 8'hB4};
	localparam logic [0:7][7:0] MULAW_MW = {8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_RUN  = 2'b01
	} tpcc_acc_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] chan;
		logic [7:0] data;
		logic [3:0] sig;
		logic       sigFrame;
		logic       mfStart;
	} tpcc_beat_t;
endpackage : tpcc_pkg

// ===== bench/tpcc_payload_cfg_assertions.sv
// Port checker for the payload control config block.
// Assumes one clock domain; bound to tpcc_payload_cfg below.
`timescale 1ns/1ps
module tpcc_payload_cfg_checker (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 rst_n,
	// Register bus
	input wire logic                 read,
	input wire logic                 write,
	input wire logic [31:0]          readdata,
	input wire logic                 waitrequest,
	// Streams
	input wire tpcc_pkg::tpcc_beat_t txIn,
	input wire tpcc_pkg::tpcc_beat_t txOut,
	input wire tpcc_pkg::tpcc_beat_t rxIn,
	input wire tpcc_pkg::tpcc_beat_t rxOut
);
	import tpcc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	a_answer_one_cycle: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_request_answered: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered next cycle");
	a_no_idle_answer: assert property (!read && !write && waitrequest |=> waitrequest)
		else $error("answer without request");
	a_read_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
		else $error("readdata upper bits not zero");
	a_tx_beat_follows: assert property (txIn.valid |=> txOut.valid && txOut.chan == $past(txIn.chan))
		else $error("tx beat lost or channel changed");
	a_tx_idle_quiet: assert property (!txIn.valid |=> !txOut.valid)
		else $error("tx beat without input");
	a_tx_flags_kept: assert property (txIn.valid |=> $past(txIn.mfStart) == txOut.mfStart)
		else $error("tx multiframe flag changed");
	a_rx_beat_follows: assert property (rxIn.valid |=> rxOut.valid && rxOut.sigFrame == $past(rxIn.sigFrame))
		else $error("rx beat lost or flag changed");
	a_rx_idle_quiet: assert property (!rxIn.valid |=> !rxOut.valid)
		else $error("rx beat without input");
	c_write_done: cover property (write && !waitrequest);
	c_read_done: cover property (read && !waitrequest);
	c_tx_beat: cover property (txIn.valid ##1 txOut.valid);
endmodule : tpcc_payload_cfg_checker

bind tpcc_payload_cfg tpcc_payload_cfg_checker u_chk (.clk(clk), .rst_n(rst_n), .read(read),
	.write(write), .readdata(readdata), .waitrequest(waitrequest), .txIn(txIn),
	.txOut(txOut), .rxIn(rxIn), .rxOut(rxOut));

// ===== bench/tpcc_payload_cfg_tb.sv
// Self-checking bench for the payload control config block.
// Assumes the checker is bound by its own file; one 50 MHz clock.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tpcc_payload_cfg_tb;
	import tpcc_pkg::*;
	logic                clk, rst_n, read, write, sfFmt, esf, inSync, wreq;
	logic [ADDR_W-1:0]   address;
	logic [31:0]         wdata, rdata;
	logic [3:0]          be;
	logic [7:0]          loopData, rd;
	tpcc_beat_t          txIn, rxIn, txOut, rxOut, b;
	int                  fails, n_checks, cyc;
	tpcc_payload_cfg u_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(wdata), .byteenable(be), .readdata(rdata),
		.waitrequest(wreq), .superFrameFmt(sfFmt), .esfFormat(esf), .rxInSync(inSync),
		.txIn(txIn), .txLoopData(loopData), .txOut(txOut), .rxIn(rxIn), .rxOut(rxOut));
	////////////////////////////////////////////////////////////////////////////////
	task automatic bus(input logic isRd, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		read    <= isRd;
		write   <= !isRd;
		address <= {idx, 2'b00};
		wdata   <= {24'h0, d};
		do @(posedge clk); while (wreq !== 1'b0);
		rd = rdata[7:0];
		read  <= 1'b0;
		write <= 1'b0;
	endtask : bus
	// Polling keeps software off the port while an access runs
	task automatic idle(input logic [7:0] o);
		do bus(1'b1, IDX_TX_STATUS + o, 8'h00); while (rd[0] !== 1'b0);
	endtask : idle
	task automatic ind(input logic [7:0] o, input logic isRd, input logic [6:0] a,
		input logic [7:0] d);
		if (!isRd) bus(1'b0, IDX_TX_DATA + o, d);
		bus(1'b0, IDX_TX_CTRL + o, {isRd, a});
		idle(o);
		if (isRd) bus(1'b1, IDX_TX_DATA + o, 8'h00);
	endtask : ind
	task automatic beat(input logic [7:0] d, input logic [3:0] s, input logic sf, input logic mf);
		b = '{1'b1, 5'h00, d, s, sf, mf};
		@(posedge clk);
		txIn <= b;
		rxIn <= b;
		@(posedge clk);
		txIn <= '0;
		rxIn <= '0;
		#1;
	endtask : beat
	task automatic txCase(input logic [7:0] cfg, input logic [7:0] d, input logic sf,
		input logic [7:0] ex);
		bus(1'b0, IDX_TX_CFG, cfg);
		beat(d, 4'h0, sf, 1'b0);
		`CHK("tx data", ex, txOut.data)
	endtask : txCase
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		bus(1'b1, IDX_TX_CFG, 8'h00);
		`CHK("tx cfg reset", TX_CFG_RST, rd)
		bus(1'b1, IDX_RX_CFG, 8'h00);
		`CHK("rx cfg reset", RX_CFG_RST, rd)
		bus(1'b1, IDX_TX_ENA, 8'h00);
		`CHK("enable reset", ENA_RST, rd)
		bus(1'b1, 8'h00, 8'h00);
		`CHK("unmapped read", 8'h00, rd)
		bus(1'b0, IDX_NONE, 8'hFF);
		bus(1'b1, IDX_NONE, 8'h00);
		`CHK("unmapped write", 8'h00, rd)
		$display("t_regs done");
	endtask : t_regs
	task automatic t_ind();
		bus(1'b0, IDX_TX_DATA, 8'h5A);
		bus(1'b0, IDX_TX_CTRL, 8'h21);
		bus(1'b1, IDX_TX_STATUS, 8'h00);
		`CHK("busy while running", 8'h01, rd)
		idle(8'h00);
		ind(8'h00, 1'b1, 7'h21, 8'h00);
		`CHK("tx trunk code back", 8'h5A, rd)
		ind(8'h00, 1'b0, 7'h41, 8'h0C);
		ind(8'h05, 1'b0, 7'h41, 8'h0C);
		ind(8'h05, 1'b1, 7'h41, 8'h00);
		`CHK("rx row back", 8'h0C, rd)
		ind(8'h00, 1'b0, 7'h59, 8'hFF);
		ind(8'h00, 1'b1, 7'h41, 8'h00);
		`CHK("out of range write", 8'h0C, rd)
		bus(1'b0, IDX_TX_CTRL, 8'h99);
		bus(1'b0, IDX_TX_CTRL, 8'h21);
		idle(8'h00);
		bus(1'b1, IDX_TX_CTRL, 8'h00);
		`CHK("ctrl kept while busy", 8'h99, rd)
		bus(1'b1, IDX_TX_DATA, 8'h00);
		`CHK("out of range read", 8'h00, rd)
		$display("t_ind done");
	endtask : t_ind
	task automatic t_tx();
		bus(1'b0, IDX_TX_ENA, 8'h01);
		txCase(8'h00, 8'h00, 1'b0, 8'h00);
		txCase(8'h28, 8'h00, 1'b0, 8'h00);
		txCase(8'h08, 8'h00, 1'b0, 8'h01);
		txCase(8'h08, 8'h00, 1'b1, 8'h02);
		txCase(8'h10, 8'h40, 1'b0, 8'h41);
		txCase(8'h18, 8'h00, 1'b0, 8'h02);
		txCase(8'h20, 8'h00, 1'b0, DDS_BYTE);
		txCase(8'h01, 8'h00, 1'b0, 8'h5A);
		txCase(8'h02, 8'h11, 1'b0, ALAW_MW[0]);
		txCase(8'h03, 8'h11, 1'b0, MULAW_MW[0]);
		txCase(8'h04, 8'h11, 1'b0, 8'hC3);
		ind(8'h00, 1'b0, 7'h01, {SUB_ALAW, 5'h00});
		txCase(8'h00, 8'h11, 1'b0, ALAW_MW[0]);
		bus(1'b0, IDX_TX_ENA, 8'h00);
		txCase(8'h10, 8'h40, 1'b0, 8'h40);
		$display("t_tx done");
	endtask : t_tx
	task automatic t_sig();
		bus(1'b0, IDX_TX_ENA, 8'h01);
		bus(1'b0, IDX_TX_CFG, 8'h80);
		sfFmt  <= 1'b1;
		inSync <= 1'b1;
		beat(8'h00, 4'hA, 1'b0, 1'b1);
		beat(8'h00, 4'h5, 1'b0, 1'b0);
		`CHK("tx snapshot", 4'hA, txOut.sig)
		`CHK("rx snapshot", 4'hA, rxOut.sig)
		bus(1'b0, IDX_TX_CFG, 8'h40);
		beat(8'h00, 4'h5, 1'b0, 1'b0);
		`CHK("trunk code", 4'hC, txOut.sig)
		bus(1'b0, IDX_TX_CFG, 8'h00);
		bus(1'b0, IDX_TX_ENA, 8'h09);
		esf <= 1'b1;
		beat(8'h00, 4'hF, 1'b0, 1'b0);
		`CHK("nibble position", 4'hC, txOut.sig)
		ind(8'h00, 1'b0, 7'h41, 8'h1F);
		bus(1'b0, IDX_RX_CFG, 8'h02);
		beat(8'h00, 4'h5, 1'b0, 1'b0);
		`CHK("channel trunk", 4'hC, txOut.sig)
		`CHK("rx milliwatt", ALAW_MW[0], rxOut.data)
		$display("t_sig done");
	endtask : t_sig
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Ceiling far above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		{read, write, sfFmt, esf, inSync, rst_n} = '0;
		address  = '0;
		wdata    = '0;
		be       = 4'hF;
		loopData = 8'hC3;
		txIn     = '0;
		rxIn     = '0;
		cyc      = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_ind();
		t_tx();
		t_sig();
		tally_and_finish();
	end
endmodule : tpcc_payload_cfg_tb
